// *** shared/sbst_defs.svh ***
/*
 * Constants of the SRAM boundary scan test port: scan register sizes,
 * instruction reset value, capture pattern and register bus offsets.
 * Assumes nothing; definitions only.
 */
`ifndef SBST_DEFS_SVH
`define SBST_DEFS_SVH

// Scan register sizes
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       71
// Instruction register contents after reset
`define SBST_IR_RESET    3'h1
// Pattern loaded into the instruction register in Capture-IR
`define SBST_IR_CAPT     3'h1
// Bypass bit value on capture
`define SBST_BYP_CAPT    1'h0
// Register bus byte offsets
`define SBST_OFF_CTRL    8'h00
`define SBST_OFF_STAT    8'h04
`define SBST_OFF_ID      8'h08
// Field positions and control word reset value
`define SBST_CTRL_HOLD   0
`define SBST_CTRL_RESET  32'h0000_0000
`define SBST_STAT_IR_LO  16
`define SBST_STAT_OE     19
`define SBST_STAT_HIZ    20
// Bus answers
`define SBST_RESP_OKAY   2'h0
`define SBST_RESP_SLVERR 2'h2

`endif

// *** shared/sbst_pkg.sv ***
/*
 * Types of the SRAM boundary scan test port: controller states and
 * instruction codes.
 * Assumes sbst_defs.svh holds the numeric constants.
 */
package sbst_pkg;

  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SHF_DR  = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SHF_IR  = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } sbst_state_t;

  // Instruction codes
  typedef enum logic [2:0] {
    INS_EXTEST  = 3'h0,
    INS_IDCODE  = 3'h1,
    INS_SAMPZ   = 3'h2,
    INS_RSV3    = 3'h3,
    INS_SAMPLE  = 3'h4,
    INS_RSV5    = 3'h5,
    INS_RSV6    = 3'h6,
    INS_BYPASS  = 3'h7
  } sbst_ins_t;

  // Data register choice
  typedef enum logic [2:0] {
    SEL_BSR = 3'h1,
    SEL_ID  = 3'h2,
    SEL_BYP = 3'h4
  } sbst_sel_t;

endpackage

// *** src/sbst_sync.sv ***
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes each bit is an independent level; words are not coherent.
 */
`timescale 1ns/1ps
`default_nettype none

module sbst_sync #(
  parameter int W = 74
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;   // First stage, read only by the second

  // Two stages, both cleared by reset; no test clock edge is seen then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sbst_sync

`default_nettype wire

// *** src/sbst_tap.sv ***
/*
 * Boundary scan test access port of a synchronous SRAM, with an
 * AXI4-Lite register slave for control and status.
 * Assumes tck, tms, tdi and the I/O ring arrive asynchronously and are
 * sampled by aclk, which runs well above twice the test clock rate.
 */
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap
  import sbst_pkg::*;
#(
  // Arbitrary identification value; bit 0 must stay one
  parameter logic [31:0] ID_CODE = 32'h1234_5001
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Test port pins
  input  wire logic                   tck,
  input  wire logic                   tms_i,
  input  wire logic                   tms_drv,
  input  wire logic                   tdi_i,
  input  wire logic                   tdi_drv,
  output logic                        tdo_o,
  output logic                        tdo_oe,
  // I/O ring levels and output disable toward the SRAM pads
  input  wire logic [`SBST_BSR_W-1:0] io_ring,
  output logic                        sram_hiz,
  // AXI4-Lite slave
  input  wire logic [7:0]             s_awaddr,
  input  wire logic                   s_awvalid,
  output logic                        s_awready,
  input  wire logic [31:0]            s_wdata,
  input  wire logic [3:0]             s_wstrb,
  input  wire logic                   s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire logic                   s_bready,
  input  wire logic [7:0]             s_araddr,
  input  wire logic                   s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire logic                   s_rready
);

  localparam int SW = `SBST_BSR_W + 3;

  // Synchronised pin levels
  logic [SW-1:0]          sync_q;
  logic [`SBST_BSR_W-1:0] ring_s;      // Ring levels in aclk domain
  logic                   tck_s;       // Test clock level
  logic                   tms_s;       // Mode select, pulled up
  logic                   tdi_s;       // Data in, pulled up
  logic                   tck_d;       // Previous test clock level
  logic                   tck_rise;    // Rising edge seen
  logic                   tck_fall;    // Falling edge seen

  // Controller and scan registers
  sbst_state_t            state_reg;   // Controller state
  sbst_state_t            state_next;  // Next state from TMS
  logic [`SBST_IR_W-1:0]  ir_reg;      // Active instruction
  logic [`SBST_IR_W-1:0]  irsh_reg;    // Instruction shift stage
  logic [`SBST_BSR_W-1:0] bsr_reg;     // Boundary scan register
  logic [`SBST_ID_W-1:0]  id_reg;      // Identification shift register
  logic                   byp_reg;     // Bypass bit
  logic                   tdo_reg;     // Output data flop
  logic                   oe_reg;      // Output enable flop
  logic                   hiz_reg;     // SRAM output disable
  sbst_sel_t              sel;         // Chosen data register

  // Register bus state
  logic [31:0]            ctrl_reg;    // Control word
  logic                   aw_have;     // Write address held
  logic                   w_have;      // Write data held
  logic [7:0]             awaddr_reg;  // Held write address
  logic [31:0]            wdata_reg;   // Held write data
  logic [3:0]             wstrb_reg;   // Held byte enables
  logic                   bvalid_reg;  // Write answer pending
  logic [1:0]             bresp_reg;   // Write answer code
  logic                   rvalid_reg;  // Read answer pending
  logic [1:0]             rresp_reg;   // Read answer code
  logic [31:0]            rdata_reg;   // Read answer data
  logic                   tap_hold;    // Software holds controller reset

  // Data register chosen by an instruction; reserved codes use bypass
  function automatic sbst_sel_t dr_sel(input logic [2:0] ins);
    case (ins)
      INS_EXTEST, INS_SAMPZ, INS_SAMPLE: dr_sel = SEL_BSR;
      INS_IDCODE:                        dr_sel = SEL_ID;
      default:                           dr_sel = SEL_BYP;
    endcase
  endfunction

  // Instructions that disable the SRAM outputs
  function automatic logic is_hiz(input logic [2:0] ins);
    is_hiz = (ins == INS_EXTEST) || (ins == INS_SAMPZ);
  endfunction

  // Two flops on every pin level before any use
  sbst_sync #(
    .W (SW)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({io_ring, tck, (tms_drv ? tms_i : 1'b1),
                (tdi_drv ? tdi_i : 1'b1)}),
    .sync_out (sync_q)
  );

  assign ring_s = sync_q[SW-1:3];
  assign tck_s  = sync_q[2];
  assign tms_s  = sync_q[1];
  assign tdi_s  = sync_q[0];
  assign sel    = dr_sel(ir_reg);
  assign tap_hold = ctrl_reg[`SBST_CTRL_HOLD];

  // Test clock edge finder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // Controller transitions on TMS
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:  state_next = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_next = tms_s ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = tms_s ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_next = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_next = tms_s ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = tms_s ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   state_next = ST_RESET;
    endcase
  end

  // State register, stepped on test clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RESET;
    end else if (tap_hold) begin
      state_reg <= ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // Instruction shift stage and active instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_reg   <= `SBST_IR_RESET;
      irsh_reg <= `SBST_IR_CAPT;
    end else if (state_reg == ST_RESET) begin
      ir_reg   <= `SBST_IR_RESET;
    end else if (tck_rise) begin
      case (state_reg)
        ST_CAP_IR: irsh_reg <= `SBST_IR_CAPT;
        ST_SHF_IR: irsh_reg <= {tdi_s, irsh_reg[2:1]};
        ST_UPD_IR: ir_reg   <= irsh_reg;
        default: begin
          // Hold
        end
      endcase
    end
  end

  // Boundary scan register: capture only, never drives the ring
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bsr_reg <= '0;
    end else if (tck_rise && sel == SEL_BSR) begin
      if (state_reg == ST_CAP_DR) begin
        bsr_reg <= ring_s;
      end else if (state_reg == ST_SHF_DR) begin
        bsr_reg <= {tdi_s, bsr_reg[`SBST_BSR_W-1:1]};
      end
    end
  end

  // Identification register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_reg <= ID_CODE;
    end else if (tck_rise && sel == SEL_ID) begin
      if (state_reg == ST_CAP_DR) begin
        id_reg <= {ID_CODE[31:1], 1'b1};
      end else if (state_reg == ST_SHF_DR) begin
        id_reg <= {tdi_s, id_reg[`SBST_ID_W-1:1]};
      end
    end
  end

  // Bypass bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byp_reg <= `SBST_BYP_CAPT;
    end else if (tck_rise && sel == SEL_BYP) begin
      if (state_reg == ST_CAP_DR) begin
        byp_reg <= `SBST_BYP_CAPT;
      end else if (state_reg == ST_SHF_DR) begin
        byp_reg <= tdi_s;
      end
    end
  end

  // Serial output, changed only on test clock fall or cleared by the hold bit
  always_ff @(posedge aclk) begin
    if (!aresetn || tap_hold) begin
      tdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (tck_fall) begin
      oe_reg <= (state_reg == ST_SHF_DR) || (state_reg == ST_SHF_IR);
      if (state_reg == ST_SHF_IR) begin
        tdo_reg <= irsh_reg[0];
      end else if (sel == SEL_BSR) begin
        tdo_reg <= bsr_reg[0];
      end else if (sel == SEL_ID) begin
        tdo_reg <= id_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  // SRAM output disable follows the active instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hiz_reg <= 1'b0;
    end else begin
      hiz_reg <= is_hiz(ir_reg);
    end
  end

  assign tdo_o    = tdo_reg;
  assign tdo_oe   = oe_reg;
  assign sram_hiz = hiz_reg;

  // Write channels taken independently, answered once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have    <= 1'b0;
      w_have     <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have    <= 1'b1;
        awaddr_reg <= s_awaddr;
      end else if (aw_have && w_have) begin
        aw_have <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have    <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end else if (aw_have && w_have) begin
        w_have <= 1'b0;
      end
    end
  end

  assign s_awready = !aw_have && !bvalid_reg;
  assign s_wready  = !w_have && !bvalid_reg;

  // Register write and write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg   <= `SBST_CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SBST_RESP_OKAY;
    end else if (aw_have && w_have) begin
      bvalid_reg <= 1'b1;
      if (awaddr_reg[7:2] == `SBST_OFF_CTRL >> 2) begin
        bresp_reg <= `SBST_RESP_OKAY;
        if (wstrb_reg[0]) begin
          ctrl_reg[7:0] <= wdata_reg[7:0];
        end
      end else if (awaddr_reg[7:2] == `SBST_OFF_STAT >> 2 ||
                   awaddr_reg[7:2] == `SBST_OFF_ID >> 2) begin
        bresp_reg <= `SBST_RESP_OKAY; // Read-only, write ignored
      end else begin
        bresp_reg <= `SBST_RESP_SLVERR; // Unmapped
      end
    end else if (bvalid_reg && s_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_bvalid = bvalid_reg;
  assign s_bresp  = bresp_reg;

  // Read answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `SBST_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (s_arvalid && s_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `SBST_RESP_OKAY;
      if (s_araddr[7:2] == `SBST_OFF_CTRL >> 2) begin
        rdata_reg <= {24'h00_0000, ctrl_reg[7:0]};
      end else if (s_araddr[7:2] == `SBST_OFF_STAT >> 2) begin
        rdata_reg <= {11'h000, hiz_reg, oe_reg, ir_reg, state_reg};
      end else if (s_araddr[7:2] == `SBST_OFF_ID >> 2) begin
        rdata_reg <= {ID_CODE[31:1], 1'b1};
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `SBST_RESP_SLVERR; // Unmapped
      end
    end else if (rvalid_reg && s_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_arready = !rvalid_reg;
  assign s_rvalid  = rvalid_reg;
  assign s_rdata   = rdata_reg;
  assign s_rresp   = rresp_reg;

endmodule // sbst_tap

`default_nettype wire

// *** test/sbst_tap_props.sv ***
/* Concurrent checks on the test port outputs.
   Assumes it is bound onto sbst_tap. */
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module sbst_tap_props #(
  parameter logic [31:0] ID_CODE = 32'h1234_5001
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        tck,
  input wire logic        tdo_o,
  input wire logic        tdo_oe,
  input wire logic        sram_hiz,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [7:0]  s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready
);
  // One domain: aclk with its synchronous reset
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rst_quiet: assert property ($past(!aresetn) |->
    !tdo_oe && !sram_hiz && !s_bvalid && !s_rvalid)
    else $error("outputs active after reset");
  a_tdo_fall: assert property
    (($changed(tdo_o) || $changed(tdo_oe)) |-> !tck && !$past(tck))
    else $error("serial output moved while test clock high");
  a_id_read: assert property (s_arvalid && s_arready &&
    s_araddr == `SBST_OFF_ID |=> s_rdata == (ID_CODE | 32'h1)
    && s_rresp == `SBST_RESP_OKAY) else $error("bad identity read");
  a_bad_addr: assert property (s_arvalid && s_arready &&
    s_araddr == 8'h0c |=> s_rresp == `SBST_RESP_SLVERR &&
    s_rdata == 32'h0) else $error("unmapped read not refused");
  a_r_lat: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_b_lat: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |-> ##2 s_bvalid) else $error("write answer late");
  a_b_hold: assert property (s_bvalid && !s_bready |=>
    s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid &&
    $stable(s_rdata) && $stable(s_rresp)) else $error("read answer dropped");
  a_ar_block: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answer pending");
  a_w_block: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while answer pending");
endmodule // sbst_tap_props

bind sbst_tap sbst_tap_props #(.ID_CODE(ID_CODE)) u_props (.aclk,
  .aresetn, .tck, .tdo_o, .tdo_oe, .sram_hiz, .s_awvalid, .s_awready,
  .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
  .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
`default_nettype wire

// *** test/sbst_jtag_model.sv ***
/* Board test controller model: drives test clock, mode and data.
   Assumes aclk at 50 MHz; one step is one 160 ns test clock. */
`timescale 1ns/1ps
`default_nettype none

module sbst_jtag_model (
  input  wire logic aclk,
  input  wire logic tdo_o,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms_i,
  output logic      tms_drv,
  output logic      tdi_i,
  output logic      tdi_drv
);
  logic last_q; // Last level seen on the serial output line

  // Test clock rests low between steps
  initial begin
    tck = 1'b0;
    tms_i = 1'b1;
    tms_drv = 1'b1;
    tdi_i = 1'b1;
    tdi_drv = 1'b1;
    last_q = 1'b0;
  end

  // One clock: set pins while low, sample output, rise, fall
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge aclk);
    tms_i <= tms_drv ? m : ~tms_i;
    tdi_i <= tdi_drv ? d : ~tdi_i;
    repeat (2) @(posedge aclk);
    #1;
    q = tdo_oe ? tdo_o : ~last_q; // Released line shows no old level
    last_q = q;
    @(posedge aclk);
    tck <= 1'b1;
    repeat (4) @(posedge aclk);
    tck <= 1'b0;
  endtask

  // Stop driving mode and data pins, or drive them again
  task automatic release_pins(input logic off);
    @(posedge aclk);
    tms_drv <= !off;
    tdi_drv <= !off;
  endtask
endmodule // sbst_jtag_model
`default_nettype wire

// *** test/tb_sbst_tap.sv ***
/* Self-checking bench of the test port and its register slave.
   Assumes the controller model in sbst_jtag_model. */
`timescale 1ns/1ps
`default_nettype none
`include "sbst_defs.svh"

module tb_sbst_tap;
  import sbst_pkg::*;
  localparam logic [31:0] ID_V = 32'h1234_5001; // Arbitrary value
  localparam logic [70:0] RING = 71'h5a_c3e1_0f96_2d4b_87a1;
  localparam logic [79:0] DIN = 80'hc0de_1357_9bdf_2468_ace1;
  // Codes the controller may load: reserved ones are left out
  localparam logic [14:0] CODES = {3'h7, 3'h4, 3'h2, 3'h1, 3'h0};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        tck, tms_i, tms_drv, tdi_i, tdi_drv, tdo_o, tdo_oe;
  logic [70:0] io_ring = RING;
  logic        sram_hiz, s_awready, s_wready, s_bvalid, s_arready;
  logic        s_rvalid, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic        s_arvalid = 0, s_rready = 0;
  logic [7:0]  s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata;
  logic [3:0]  s_wstrb = 4'hf;
  logic [1:0]  s_bresp, s_rresp;
  int          err_count = 0, n_compared = 0;

  always #10 aclk = ~aclk;

  sbst_tap #(.ID_CODE(ID_V)) dut (.aclk, .aresetn, .tck, .tms_i,
    .tms_drv, .tdi_i, .tdi_drv, .tdo_o, .tdo_oe, .io_ring, .sram_hiz,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  sbst_jtag_model jt (.aclk, .tdo_o, .tdo_oe, .tck, .tms_i, .tms_drv,
    .tdi_i, .tdi_drv);

  task automatic chk(input string nm, input logic [79:0] e,
                     input logic [79:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task finish_test;
    $display("%0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Write one word; readys judged on the low phase before the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    hb = 1'b0;
    r = 2'h3;
    while (!hb) begin
      @(negedge aclk);
      ha = s_awvalid && s_awready;
      hw = s_wvalid && s_wready;
      hb = s_bvalid && s_bready;
      if (hb) r = s_bresp;
      @(posedge aclk);
      if (ha) s_awvalid <= 1'b0;
      if (hw) s_wvalid <= 1'b0;
      if (hb) s_bready <= 1'b0;
    end
  endtask

  // Read one word
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hr;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    hr = 1'b0;
    r = 2'h3;
    while (!hr) begin
      @(negedge aclk);
      ha = s_arvalid && s_arready;
      hr = s_rvalid && s_rready;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
      if (ha) s_arvalid <= 1'b0;
      if (hr) s_rready <= 1'b0;
    end
  endtask

  // Register map, read-only identity, unmapped place, hold bit
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    logic        q;
    rd(`SBST_OFF_STAT, d, r);
    chk("stat", 32'h0001_0001, d);
    wr(`SBST_OFF_ID, 32'h0, r);
    chk("id wr resp", `SBST_RESP_OKAY, r);
    wr(8'h0c, 32'h0, r);
    chk("bad wr resp", `SBST_RESP_SLVERR, r);
    rd(`SBST_OFF_ID, d, r);
    chk("id", ID_V | 32'h1, d);
    chk("id resp", `SBST_RESP_OKAY, r);
    rd(8'h0c, d, r);
    chk("bad resp", `SBST_RESP_SLVERR, r);
    wr(`SBST_OFF_CTRL, 32'h1, r);
    chk("ctrl wr resp", `SBST_RESP_OKAY, r);
    rd(`SBST_OFF_CTRL, d, r);
    chk("ctrl", 32'h1, d);
    jt.step(1'b0, 1'b0, q);
    jt.step(1'b0, 1'b0, q);
    rd(`SBST_OFF_STAT, d, r);
    chk("held stat", 32'h0001_0001, d);
    wr(`SBST_OFF_CTRL, 32'h0, r);
    $display("test regs done");
  endtask

  // Each code in CODES: load, check decode, then scan 80 bits through
  task automatic t_codes;
    logic [79:0] o, e;
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  p, cv;
    logic        q, h;
    int          n;
    jt.step(1'b0, 1'b0, q);
    p = 3'h1;
    // Only legal codes are loaded; reserved ones stay untouched
    for (int c = 0; c < 5; c++) begin
      cv = CODES[3*c +: 3];
      jt.step(1'b1, 1'b0, q);
      jt.step(1'b1, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      for (int i = 0; i < 3; i++) begin
        jt.step(i == 2, cv[i], q);
        o[i] = q;
      end
      rd(`SBST_OFF_STAT, d, r);
      chk("ir held", p, d[18:16]);
      jt.step(1'b1, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      chk("ir capture", 3'h1, o[2:0]);
      h = (cv == 3'h0) || (cv == 3'h2);
      rd(`SBST_OFF_STAT, d, r);
      chk("stat", {11'h0, h, 1'b0, cv, 16'h0002}, d);
      chk("hiz", h, sram_hiz);
      n = cv == 3'h1 ? 32 : (cv == 3'h7) ? 1 : 71;
      e = (DIN << n) | (cv == 3'h1 ? ID_V : n == 71 ? RING : 80'h0);
      jt.step(1'b1, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      for (int i = 0; i < 80; i++) begin
        jt.step(i == 79, DIN[i], q);
        o[i] = q;
      end
      jt.step(1'b1, 1'b0, q);
      jt.step(1'b0, 1'b0, q);
      chk("dr chain", e, o);
      p = cv;
    end
    $display("test codes done");
  endtask

  // Reset from Shift-DR with mode and data pins left floating
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    logic        q;
    jt.step(1'b1, 1'b0, q);
    jt.step(1'b0, 1'b0, q);
    jt.step(1'b0, 1'b0, q);
    repeat (4) @(posedge aclk);
    chk("oe shift", 1'b1, tdo_oe);
    jt.release_pins(1'b1);
    repeat (5) jt.step(1'b0, 1'b0, q);
    jt.release_pins(1'b0);
    repeat (4) @(posedge aclk);
    rd(`SBST_OFF_STAT, d, r);
    chk("reset stat", 32'h0001_0001, d);
    chk("oe off", 1'b0, tdo_oe);
    $display("test reset done");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs;
    t_codes;
    t_reset;
    finish_test;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    finish_test;
  end
endmodule // tb_sbst_tap
`default_nettype wire
